// ---- hdl/msc_pkg.sv ----
// constants of the motor speed controller register map
package msc_pkg;

    // ========================================================
    // register spaces and answer codes
    localparam logic [1:0] SPACE_INPUT = 2'h0;
    localparam logic [1:0] SPACE_HOLD = 2'h1;
    localparam logic [1:0] SPACE_COIL = 2'h2;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;

    // ========================================================
    // input register offsets
    localparam logic [15:0] IR_OUTPUT_LEVEL_NOW = 16'h0001;
    localparam logic [15:0] IR_OUTPUT_STEP_NOW = 16'h0002;
    localparam logic [15:0] IR_MIN_LEVEL_READBACK = 16'h0003;
    localparam logic [15:0] IR_MAX_LEVEL_READBACK = 16'h0004;
    localparam logic [15:0] IR_REGULATION_DIR_READBACK = 16'h0005;
    localparam logic [15:0] IR_STARTUP_KIND_READBACK = 16'h0006;
    localparam logic [15:0] IR_KICK_DURATION_READBACK = 16'h0007;
    localparam logic [15:0] IR_UNREGULATED_OUTPUT_READBACK = 16'h0008;
    localparam logic [15:0] IR_UNIT_WORKING_STATE = 16'h000a;
    localparam logic [15:0] IR_LAST = 16'h000a;

    // ========================================================
    // holding register and coil offsets
    localparam logic [15:0] HR_NODE_ADDRESS = 16'h0001;
    localparam logic [15:0] HR_LINE_RATE_SELECT = 16'h0002;
    localparam logic [15:0] HR_PARITY_SELECT = 16'h0003;
    localparam logic [15:0] HR_PART_TYPE_CODE = 16'h0004;
    localparam logic [15:0] HR_HARDWARE_REVISION = 16'h0005;
    localparam logic [15:0] HR_FIRMWARE_REVISION = 16'h0006;
    localparam logic [15:0] HR_CONTROL_SOURCE = 16'h0007;
    localparam logic [15:0] HR_OVERRIDE_ENABLE = 16'h0008;
    localparam logic [15:0] HR_MIN_LEVEL_SET = 16'h000b;
    localparam logic [15:0] HR_MAX_LEVEL_SET = 16'h000c;
    localparam logic [15:0] HR_REGULATION_DIR_SET = 16'h000d;
    localparam logic [15:0] HR_STARTUP_KIND_SET = 16'h000e;
    localparam logic [15:0] HR_KICK_DURATION_SET = 16'h000f;
    localparam logic [15:0] HR_TERMINATION_SET = 16'h0010;
    localparam logic [15:0] HR_OVERRIDE_LEVEL = 16'h0015;
    localparam logic [15:0] HR_LAST = 16'h001e;
    localparam logic [15:0] COIL_UNREGULATED_RELAY_SWITCH = 16'h0001;

    // ========================================================
    // reset values
    localparam logic [7:0] RST_NODE_ADDRESS = 8'h01;
    localparam logic [2:0] RST_LINE_RATE = 3'h2;
    localparam logic [1:0] RST_PARITY = 2'h1;
    localparam logic [6:0] RST_MIN_LEVEL = 7'h1e;
    localparam logic [6:0] RST_MAX_LEVEL = 7'h64;
    localparam logic [3:0] RST_KICK = 4'h5;
    localparam logic RST_RELAY = 1'b1;

    // ========================================================
    // permitted ranges and codes
    localparam logic [15:0] NODE_ADDRESS_MIN = 16'h0001;
    localparam logic [15:0] NODE_ADDRESS_MAX = 16'h00f7;
    localparam logic [15:0] LINE_RATE_MAX = 16'h0006;
    localparam logic [15:0] PARITY_MAX = 16'h0002;
    localparam logic [15:0] MIN_LEVEL_LOW = 16'h001e;
    localparam logic [15:0] MIN_LEVEL_HIGH = 16'h0041;
    localparam logic [15:0] MAX_LEVEL_LOW = 16'h004b;
    localparam logic [15:0] MAX_LEVEL_HIGH = 16'h0064;
    localparam logic [15:0] KICK_LOW = 16'h0003;
    localparam logic [15:0] KICK_HIGH = 16'h0009;
    localparam logic [15:0] OVERRIDE_LOW = 16'h001e;
    localparam logic [15:0] OVERRIDE_HIGH = 16'h0064;
    localparam logic [3:0] STEP_TOP = 4'h9;
    localparam logic [1:0] UNIT_OFF = 2'h0;
    localparam logic [1:0] UNIT_RUNNING = 2'h1;
    localparam logic [1:0] UNIT_BUS = 2'h2;

endpackage

// ---- hdl/msc_step_map.sv ----
// step to output level mapping between the minimum and maximum levels
`timescale 1ns/1ps
module msc_step_map
    import msc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] step,
    input wire logic [6:0] min_level,
    input wire logic [6:0] max_level,
    input wire logic inverse,
    output logic [6:0] level
);

    // ========================================================
    // proportional mapping
    // steps above the top step are clamped so a bad menu value cannot overshoot
    logic [3:0] step_clamped;
    logic [3:0] step_used;
    logic [6:0] span;
    logic [10:0] scaled;
    logic [6:0] next_level;
    assign step_clamped = (step > STEP_TOP) ? STEP_TOP : step;
    assign step_used = inverse ? (STEP_TOP - step_clamped) : step_clamped;
    assign span = (max_level > min_level) ? (max_level - min_level) : 7'h00;
    assign scaled = (11'(span) * 11'(step_used)) / 11'(STEP_TOP);
    assign next_level = min_level + scaled[6:0];

    // registered so the main block sees a settled level
    always_ff @(posedge clk)
    begin
        if (rst)
            level <= 7'h00;
        else if (ce)
            level <= next_level;
    end

    AST_MAP_ENDS: assert property (@(posedge clk) disable iff (rst)
        ce && step_used == 4'h0 |=> level == $past(min_level))
        else $error("step 0 does not give the minimum level");
    AST_MAP_TOP: assert property (@(posedge clk) disable iff (rst)
        ce && step_used == STEP_TOP && max_level >= min_level |=> level == $past(max_level))
        else $error("top step does not give the maximum level");

endmodule

// ---- hdl/msc_regmap.sv ----
// register map and output selection of the stepped motor speed controller
`timescale 1ns/1ps
module msc_regmap
    import msc_pkg::*;
#(
    parameter logic [15:0] PART_TYPE_CODE = 16'h00a5, // arbitrary value
    parameter logic [15:0] HARDWARE_REVISION = 16'h0011, // arbitrary value
    parameter logic [15:0] FIRMWARE_REVISION = 16'h0022 // arbitrary value
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_space,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic [7:0] rsp_exception,
    input wire logic local_on,
    input wire logic [3:0] local_step,
    input wire logic [6:0] local_min,
    input wire logic [6:0] local_max,
    input wire logic local_inverse,
    input wire logic local_soft_start,
    input wire logic [3:0] local_kick,
    output logic [6:0] output_level,
    output logic [3:0] output_step,
    output logic relay_on,
    output logic bus_termination_select,
    output logic soft_start,
    output logic [3:0] kick_seconds,
    output logic [1:0] unit_state,
    output logic [7:0] node_address,
    output logic [2:0] line_rate,
    output logic [1:0] parity_mode
);

    // ========================================================
    // stored settings
    logic control_source;
    logic override_enable;
    logic [6:0] min_level_set;
    logic [6:0] max_level_set;
    logic regulation_dir_set;
    logic startup_kind_set;
    logic [3:0] kick_duration_set;
    logic termination_set;
    logic [6:0] override_level;
    logic unregulated_relay_switch;

    // range check shared by every writable register
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ========================================================
    // request decode
    logic take, is_input, is_hold, is_coil, hold_mapped, input_mapped, coil_mapped, addr_ok, value_ok, write_ok;
    assign take = ce && req_valid;
    assign is_input = req_space == SPACE_INPUT;
    assign is_hold = req_space == SPACE_HOLD;
    assign is_coil = req_space == SPACE_COIL;
    assign input_mapped = in_range(req_addr, 16'h0001, IR_LAST);
    assign hold_mapped = in_range(req_addr, 16'h0001, HR_LAST);
    assign coil_mapped = req_addr == COIL_UNREGULATED_RELAY_SWITCH;
    assign addr_ok = (is_input && input_mapped) || (is_hold && hold_mapped) || (is_coil && coil_mapped);

    // value legality per writable address; reserved and read-only words accept anything
    always_comb
    begin
        value_ok = 1'b1;
        if (is_coil)
            value_ok = in_range(req_wdata, 16'h0000, 16'h0001);
        else
            unique case (req_addr)
                HR_NODE_ADDRESS: value_ok = in_range(req_wdata, NODE_ADDRESS_MIN, NODE_ADDRESS_MAX);
                HR_LINE_RATE_SELECT: value_ok = in_range(req_wdata, 16'h0000, LINE_RATE_MAX);
                HR_PARITY_SELECT: value_ok = in_range(req_wdata, 16'h0000, PARITY_MAX);
                HR_CONTROL_SOURCE, HR_OVERRIDE_ENABLE, HR_REGULATION_DIR_SET,
                HR_STARTUP_KIND_SET, HR_TERMINATION_SET: value_ok = in_range(req_wdata, 16'h0000, 16'h0001);
                HR_MIN_LEVEL_SET: value_ok = in_range(req_wdata, MIN_LEVEL_LOW, MIN_LEVEL_HIGH);
                HR_MAX_LEVEL_SET: value_ok = in_range(req_wdata, MAX_LEVEL_LOW, MAX_LEVEL_HIGH);
                HR_KICK_DURATION_SET: value_ok = in_range(req_wdata, KICK_LOW, KICK_HIGH);
                HR_OVERRIDE_LEVEL: value_ok = (req_wdata == 16'h0000) ||
                    in_range(req_wdata, OVERRIDE_LOW, OVERRIDE_HIGH);
                default: value_ok = 1'b1;
            endcase
    end

    // input space is read only, so a write there is an illegal function
    assign write_ok = take && req_write && addr_ok && value_ok && !is_input;

    // ========================================================
    // per-register write enables
    logic wr_hold;
    assign wr_hold = write_ok && is_hold;
    logic wr_node, wr_rate, wr_parity, wr_source, wr_ovr_en, wr_min, wr_max, wr_dir, wr_startup, wr_kick, wr_term;
    logic wr_ovr_level, wr_coil;
    assign wr_node = wr_hold && req_addr == HR_NODE_ADDRESS;
    assign wr_rate = wr_hold && req_addr == HR_LINE_RATE_SELECT;
    assign wr_parity = wr_hold && req_addr == HR_PARITY_SELECT;
    assign wr_source = wr_hold && req_addr == HR_CONTROL_SOURCE;
    assign wr_ovr_en = wr_hold && req_addr == HR_OVERRIDE_ENABLE;
    assign wr_min = wr_hold && req_addr == HR_MIN_LEVEL_SET;
    assign wr_max = wr_hold && req_addr == HR_MAX_LEVEL_SET;
    assign wr_dir = wr_hold && req_addr == HR_REGULATION_DIR_SET;
    assign wr_startup = wr_hold && req_addr == HR_STARTUP_KIND_SET;
    assign wr_kick = wr_hold && req_addr == HR_KICK_DURATION_SET;
    assign wr_term = wr_hold && req_addr == HR_TERMINATION_SET;
    assign wr_ovr_level = wr_hold && req_addr == HR_OVERRIDE_LEVEL;
    assign wr_coil = write_ok && is_coil;

    // serial settings; the link itself lives outside and reads these
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            node_address <= RST_NODE_ADDRESS;
            line_rate <= RST_LINE_RATE;
            parity_mode <= RST_PARITY;
        end
        else if (ce)
        begin
            if (wr_node)
                node_address <= req_wdata[7:0];
            if (wr_rate)
                line_rate <= req_wdata[2:0];
            if (wr_parity)
                parity_mode <= req_wdata[1:0];
        end
    end

    // bus-mode settings; ident words have no storage so writes cannot touch them
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            control_source <= 1'b0;
            override_enable <= 1'b0;
            min_level_set <= RST_MIN_LEVEL;
            max_level_set <= RST_MAX_LEVEL;
            regulation_dir_set <= 1'b0;
            startup_kind_set <= 1'b0;
            kick_duration_set <= RST_KICK;
            termination_set <= 1'b0;
            override_level <= 7'h00;
            unregulated_relay_switch <= RST_RELAY;
        end
        else if (ce)
        begin
            if (wr_source)
                control_source <= req_wdata[0];
            if (wr_ovr_en)
                override_enable <= req_wdata[0];
            if (wr_min)
                min_level_set <= req_wdata[6:0];
            if (wr_max)
                max_level_set <= req_wdata[6:0];
            if (wr_dir)
                regulation_dir_set <= req_wdata[0];
            if (wr_startup)
                startup_kind_set <= req_wdata[0];
            if (wr_kick)
                kick_duration_set <= req_wdata[3:0];
            if (wr_term)
                termination_set <= req_wdata[0];
            if (wr_ovr_level)
                override_level <= req_wdata[6:0];
            if (wr_coil)
                unregulated_relay_switch <= req_wdata[0];
        end
    end

    // ========================================================
    // effective settings: bus copies only while bus mode holds
    logic bus_mode;
    logic override_active;
    logic [6:0] eff_min;
    logic [6:0] eff_max;
    logic eff_inverse;
    logic eff_soft;
    logic [3:0] eff_kick;
    logic [1:0] next_unit_state;
    logic [6:0] mapped_level;
    assign bus_mode = control_source;
    assign override_active = bus_mode && override_enable;
    assign eff_min = bus_mode ? min_level_set : local_min;
    assign eff_max = bus_mode ? max_level_set : local_max;
    assign eff_inverse = bus_mode ? regulation_dir_set : local_inverse;
    assign eff_soft = bus_mode ? startup_kind_set : local_soft_start;
    assign eff_kick = bus_mode ? kick_duration_set : local_kick;
    assign next_unit_state = bus_mode ? UNIT_BUS : (local_on ? UNIT_RUNNING : UNIT_OFF);

    msc_step_map u_map (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .step(local_step),
        .min_level(eff_min),
        .max_level(eff_max),
        .inverse(eff_inverse),
        .level(mapped_level)
    );

    // outputs to the power stage; the off state forces zero unless overridden
    logic [6:0] next_level;
    logic next_relay;
    assign next_level = override_active ? override_level :
        ((next_unit_state == UNIT_OFF) ? 7'h00 : mapped_level);
    assign next_relay = override_active ? unregulated_relay_switch :
        (next_unit_state != UNIT_OFF);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            output_level <= 7'h00;
            output_step <= 4'h0;
            relay_on <= 1'b0;
            bus_termination_select <= 1'b0;
            soft_start <= 1'b0;
            kick_seconds <= 4'h0;
            unit_state <= UNIT_OFF;
        end
        else if (ce)
        begin
            output_level <= next_level;
            output_step <= (local_step > STEP_TOP) ? STEP_TOP : local_step;
            relay_on <= next_relay;
            bus_termination_select <= bus_mode && termination_set;
            soft_start <= eff_soft;
            kick_seconds <= eff_soft ? 4'h0 : eff_kick;
            unit_state <= next_unit_state;
        end
    end

    // ========================================================
    // read data; reserved words fall through to zero
    logic [15:0] rd_value;
    always_comb
    begin
        rd_value = 16'h0000;
        if (is_input)
            unique case (req_addr)
                IR_OUTPUT_LEVEL_NOW: rd_value = {9'h000, output_level};
                IR_OUTPUT_STEP_NOW: rd_value = {12'h000, output_step};
                IR_MIN_LEVEL_READBACK: rd_value = {9'h000, eff_min};
                IR_MAX_LEVEL_READBACK: rd_value = {9'h000, eff_max};
                IR_REGULATION_DIR_READBACK: rd_value = {15'h0000, eff_inverse};
                IR_STARTUP_KIND_READBACK: rd_value = {15'h0000, eff_soft};
                IR_KICK_DURATION_READBACK: rd_value = {12'h000, eff_kick};
                IR_UNREGULATED_OUTPUT_READBACK: rd_value = {15'h0000, relay_on};
                IR_UNIT_WORKING_STATE: rd_value = {14'h0000, unit_state};
                default: rd_value = 16'h0000;
            endcase
        else if (is_hold)
            unique case (req_addr)
                HR_NODE_ADDRESS: rd_value = {8'h00, node_address};
                HR_LINE_RATE_SELECT: rd_value = {13'h0000, line_rate};
                HR_PARITY_SELECT: rd_value = {14'h0000, parity_mode};
                HR_PART_TYPE_CODE: rd_value = PART_TYPE_CODE;
                HR_HARDWARE_REVISION: rd_value = HARDWARE_REVISION;
                HR_FIRMWARE_REVISION: rd_value = FIRMWARE_REVISION;
                HR_CONTROL_SOURCE: rd_value = {15'h0000, control_source};
                HR_OVERRIDE_ENABLE: rd_value = {15'h0000, override_enable};
                HR_MIN_LEVEL_SET: rd_value = {9'h000, min_level_set};
                HR_MAX_LEVEL_SET: rd_value = {9'h000, max_level_set};
                HR_REGULATION_DIR_SET: rd_value = {15'h0000, regulation_dir_set};
                HR_STARTUP_KIND_SET: rd_value = {15'h0000, startup_kind_set};
                HR_KICK_DURATION_SET: rd_value = {12'h000, kick_duration_set};
                HR_TERMINATION_SET: rd_value = {15'h0000, termination_set};
                HR_OVERRIDE_LEVEL: rd_value = {9'h000, override_level};
                default: rd_value = 16'h0000;
            endcase
        else if (is_coil)
            rd_value = {15'h0000, unregulated_relay_switch};
    end

    // exception priority: address first, then function, then value
    logic [7:0] next_exception;
    assign next_exception = !addr_ok ? EXC_ADDRESS :
        ((req_write && is_input) ? EXC_FUNCTION :
        ((req_write && !value_ok) ? EXC_VALUE : EXC_NONE));

    // one answer per taken request, one enabled cycle later
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            rsp_exception <= EXC_NONE;
        end
        else if (ce)
        begin
            rsp_valid <= req_valid;
            rsp_rdata <= (req_valid && !req_write && addr_ok) ? rd_value : 16'h0000;
            rsp_exception <= req_valid ? next_exception : EXC_NONE;
        end
    end

    // ========================================================
    // checks
    AST_UNIT_BUS: assert property (@(posedge clk) disable iff (rst)
        ce && control_source |=> unit_state == UNIT_BUS)
        else $error("bus mode not reported as unit state 2");
    AST_RATE_RANGE: assert property (@(posedge clk) disable iff (rst)
        line_rate <= 3'h6 && parity_mode <= 2'h2)
        else $error("serial setting out of range");
    AST_IDENT_FIXED: assert property (@(posedge clk) disable iff (rst)
        take && !req_write && is_hold && req_addr == HR_PART_TYPE_CODE |=> rsp_rdata == PART_TYPE_CODE)
        else $error("part type code changed");
    AST_MIN_RANGE: assert property (@(posedge clk) disable iff (rst)
        min_level_set >= 7'h1e && min_level_set <= 7'h41)
        else $error("minimum level setting out of range");
    AST_MAX_RANGE: assert property (@(posedge clk) disable iff (rst)
        max_level_set >= 7'h4b && max_level_set <= 7'h64)
        else $error("maximum level setting out of range");
    AST_KICK_SOFT: assert property (@(posedge clk) disable iff (rst)
        ce && eff_soft |=> kick_seconds == 4'h0 && soft_start)
        else $error("kick time applied during soft start");
    AST_TERM_STANDALONE: assert property (@(posedge clk) disable iff (rst)
        ce && !control_source |=> !bus_termination_select)
        else $error("termination connected outside bus mode");
    AST_OVERRIDE_LEVEL: assert property (@(posedge clk) disable iff (rst)
        ce && override_active |=> output_level == $past(override_level))
        else $error("override level not driven");
    AST_RELAY_COIL: assert property (@(posedge clk) disable iff (rst)
        ce && override_active |=> relay_on == $past(unregulated_relay_switch))
        else $error("relay does not follow the coil");
    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst)
        take && !req_write && is_hold && req_addr == 16'h0009 |=> rsp_valid && rsp_rdata == 16'h0000)
        else $error("reserved word not read as zero");
    AST_BAD_VALUE: assert property (@(posedge clk) disable iff (rst)
        take && req_write && is_hold && req_addr == HR_MIN_LEVEL_SET && req_wdata > 16'h0041
        |=> rsp_exception == EXC_VALUE && min_level_set == $past(min_level_set))
        else $error("out-of-range write not refused");

    COV_OVERRIDE: cover property (@(posedge clk) disable iff (rst) ce && override_active);
    COV_REFUSED: cover property (@(posedge clk) disable iff (rst) rsp_valid && rsp_exception == EXC_VALUE);
    COV_INVERSE_BUS: cover property (@(posedge clk) disable iff (rst) bus_mode && regulation_dir_set);

endmodule

// ---- verif/msc_master.sv ----
// bus master model issuing single register requests
`timescale 1ns/1ps
module msc_master (
    input wire logic clk,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic [7:0] rsp_exception,
    output logic req_valid,
    output logic req_write,
    output logic [1:0] req_space,
    output logic [15:0] req_addr,
    output logic [15:0] req_wdata
);
    initial
    begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_space = 2'h3;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
    end
    // one request; on release the address and write data flip so stale values never look valid
    task automatic xfer(input logic wr, input logic [1:0] sp, input logic [15:0] ad, wd,
                        output logic [15:0] rd, output logic [7:0] ex);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_space <= sp;
        req_addr <= ad;
        req_wdata <= wd;
        @(posedge clk);
        req_valid <= 1'b0;
        req_addr <= ~ad;
        req_wdata <= ~wd;
        n = 0;
        do @(posedge clk); while (rsp_valid !== 1'b1 && ++n < 8);
        rd = rsp_rdata;
        // a missing answer shows as an impossible code so the exception check cannot pass on silence
        ex = (rsp_valid === 1'b1) ? rsp_exception : 8'hff;
    endtask
endmodule

// ---- verif/test_motor_speed_ctrl_regmap.sv ----
// self-checking bench for the speed controller register map
`timescale 1ns/1ps
module test_motor_speed_ctrl_regmap
    import msc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, local_on = 1'b0, local_inverse = 1'b0, local_soft_start = 1'b0;
    logic [3:0] local_step = 4'h0, local_kick = 4'h4, output_step, kick_seconds;
    logic [6:0] local_min = 7'h28, local_max = 7'h50, output_level;
    logic req_valid, req_write, rsp_valid, relay_on, bus_termination_select, soft_start;
    logic [1:0] req_space, unit_state, parity_mode;
    logic [15:0] req_addr, req_wdata, rsp_rdata, rd;
    logic [7:0] rsp_exception, ex, node_address;
    logic [2:0] line_rate;
    int err_total = 0, samples_checked = 0, cycles = 0;
    always #2 clk = ~clk;
    msc_regmap #(.PART_TYPE_CODE(16'h0abc)) i_msc_regmap (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid),
        .req_write(req_write), .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_exception(rsp_exception), .local_on(local_on),
        .local_step(local_step), .local_min(local_min), .local_max(local_max), .local_inverse(local_inverse),
        .local_soft_start(local_soft_start), .local_kick(local_kick), .output_level(output_level),
        .output_step(output_step), .relay_on(relay_on), .bus_termination_select(bus_termination_select),
        .soft_start(soft_start), .kick_seconds(kick_seconds), .unit_state(unit_state),
        .node_address(node_address), .line_rate(line_rate), .parity_mode(parity_mode));
    msc_master i_msc_master (.clk(clk), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_exception(rsp_exception), .req_valid(req_valid), .req_write(req_write), .req_space(req_space),
        .req_addr(req_addr), .req_wdata(req_wdata));
    task automatic chk(input string nm, input logic [15:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one access judged on both read data and answer code
    task automatic acc(input logic wr, input logic [1:0] sp, input logic [15:0] ad, wd, re, input logic [7:0] ee);
        i_msc_master.xfer(wr, sp, ad, wd, rd, ex);
        chk("rdata", re, rd);
        chk("exception", {8'h00, ee}, {8'h00, ex});
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    task automatic finish_test;
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset;
        chk("line_rate", 16'h0002, {13'h0, line_rate});
        chk("parity_mode", 16'h0001, {14'h0, parity_mode});
        chk("unit_state", 16'h0000, {14'h0, unit_state});
        acc(1'b0, SPACE_HOLD, HR_MIN_LEVEL_SET, 16'h0, 16'h001e, EXC_NONE);
        acc(1'b0, SPACE_HOLD, HR_MAX_LEVEL_SET, 16'h0, 16'h0064, EXC_NONE);
        acc(1'b0, SPACE_HOLD, HR_KICK_DURATION_SET, 16'h0, 16'h0005, EXC_NONE);
        acc(1'b0, SPACE_COIL, COIL_UNREGULATED_RELAY_SWITCH, 16'h0, 16'h0001, EXC_NONE);
    endtask
    // refused values, read-only words and reserved places
    task automatic t_refuse;
        acc(1'b1, SPACE_HOLD, HR_MIN_LEVEL_SET, 16'h0042, 16'h0, EXC_VALUE);
        acc(1'b0, SPACE_HOLD, HR_MIN_LEVEL_SET, 16'h0, 16'h001e, EXC_NONE);
        acc(1'b1, SPACE_HOLD, HR_LINE_RATE_SELECT, 16'h0007, 16'h0, EXC_VALUE);
        acc(1'b1, SPACE_HOLD, HR_PART_TYPE_CODE, 16'h1234, 16'h0, EXC_NONE);
        acc(1'b0, SPACE_HOLD, HR_PART_TYPE_CODE, 16'h0, 16'h0abc, EXC_NONE);
        acc(1'b1, SPACE_HOLD, 16'h0009, 16'h0041, 16'h0, EXC_NONE);
        acc(1'b0, SPACE_HOLD, 16'h0009, 16'h0, 16'h0, EXC_NONE);
        acc(1'b0, SPACE_HOLD, HR_LAST + 16'h1, 16'h0, 16'h0, EXC_ADDRESS);
        acc(1'b1, SPACE_HOLD, HR_NODE_ADDRESS, 16'h00f8, 16'h0, EXC_VALUE);
        chk("node_address", 16'h0001, {8'h0, node_address});
        acc(1'b1, SPACE_INPUT, IR_OUTPUT_LEVEL_NOW, 16'h0001, 16'h0, EXC_FUNCTION);
        acc(1'b0, SPACE_INPUT, 16'h0009, 16'h0, 16'h0, EXC_NONE);
    endtask
    // standalone, then bus mode settings and override
    task automatic t_bus;
        @(posedge clk);
        local_on <= 1'b1;
        local_step <= 4'h9;
        settle;
        chk("unit_state", 16'h0001, {14'h0, unit_state});
        acc(1'b1, SPACE_HOLD, HR_CONTROL_SOURCE, 16'h0001, 16'h0, EXC_NONE);
        settle;
        chk("unit_state", 16'h0002, {14'h0, unit_state});
        chk("output_level", 16'h0064, {9'h0, output_level});
        acc(1'b1, SPACE_HOLD, HR_REGULATION_DIR_SET, 16'h0001, 16'h0, EXC_NONE);
        settle;
        chk("output_level", 16'h001e, {9'h0, output_level});
        acc(1'b1, SPACE_HOLD, HR_STARTUP_KIND_SET, 16'h0001, 16'h0, EXC_NONE);
        acc(1'b1, SPACE_HOLD, HR_TERMINATION_SET, 16'h0001, 16'h0, EXC_NONE);
        settle;
        chk("kick_seconds", 16'h0000, {12'h0, kick_seconds});
        chk("termination", 16'h0001, {15'h0, bus_termination_select});
        chk("soft_start", 16'h0001, {15'h0, soft_start});
        acc(1'b1, SPACE_HOLD, HR_OVERRIDE_ENABLE, 16'h0001, 16'h0, EXC_NONE);
        acc(1'b1, SPACE_HOLD, HR_OVERRIDE_LEVEL, 16'h0032, 16'h0, EXC_NONE);
        acc(1'b1, SPACE_COIL, COIL_UNREGULATED_RELAY_SWITCH, 16'h0, 16'h0, EXC_NONE);
        settle;
        chk("output_level", 16'h0032, {9'h0, output_level});
        chk("relay_on", 16'h0000, {15'h0, relay_on});
        acc(1'b0, SPACE_INPUT, IR_UNIT_WORKING_STATE, 16'h0, 16'h0002, EXC_NONE);
        // back to standalone: override and bus copies must drop out
        acc(1'b1, SPACE_HOLD, HR_CONTROL_SOURCE, 16'h0000, 16'h0, EXC_NONE);
        settle;
        chk("output_level", 16'h0050, {9'h0, output_level});
        chk("relay_on", 16'h0001, {15'h0, relay_on});
        chk("termination", 16'h0000, {15'h0, bus_termination_select});
        chk("kick_seconds", 16'h0004, {12'h0, kick_seconds});
        // clock enable low freezes the outputs
        ce <= 1'b0;
        local_step <= 4'h3;
        settle;
        chk("output_step", 16'h0009, {12'h0, output_step});
        ce <= 1'b1;
        settle;
        chk("output_step", 16'h0003, {12'h0, output_step});
        chk("output_level", 16'h0035, {9'h0, output_level});
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            finish_test;
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_refuse;
        t_bus;
        finish_test;
    end
endmodule
